/* src/uart_pkg.sv */
package uart_pkg;

  // register byte offsets on the 8-bit address window
  localparam logic [7:0] buffer_offset = 8'h00;
  localparam logic [7:0] control_offset = 8'h04;
  localparam logic [7:0] power_offset = 8'h08;
  localparam logic [7:0] clock_offset = 8'h0C;
  localparam logic [7:0] t1_reload_offset = 8'h10;
  localparam logic [7:0] t2_reload_low_offset = 8'h14;
  localparam logic [7:0] t2_reload_high_offset = 8'h18;
  localparam logic [7:0] t2_control_offset = 8'h1C;
  localparam logic [7:0] irq_enable_offset = 8'h20;

  // serial_control_reg field positions
  localparam int ctl_mode_hi = 7;
  localparam int ctl_mode_lo = 6;
  localparam int ctl_mpc = 5;
  localparam int ctl_ren = 4;
  localparam int ctl_tx_ninth = 3;
  localparam int ctl_rx_ninth = 2;
  localparam int ctl_tx_done = 1;
  localparam int ctl_rx_done = 0;
  // other field positions
  localparam int pwr_doubler = 7;
  localparam int clk_t1_sys = 4;
  localparam int clk_t1_ext = 3;
  localparam int t2_rx_sel = 5;
  localparam int t2_tx_sel = 4;
  localparam int t2_ext_sel = 1;
  localparam int irq_en_bit = 0;

  // operating modes
  localparam logic [1:0] mode_sync = 2'h0;
  localparam logic [1:0] mode_async8 = 2'h1;
  localparam logic [1:0] mode_async9_fixed = 2'h2;
  localparam logic [1:0] mode_async9_var = 2'h3;

  // timing counts
  localparam logic [3:0] sync_div_last = 4'hB;
  localparam logic [3:0] sync_div_half = 4'h6;
  localparam logic [3:0] oversample_last = 4'hF;
  localparam logic [3:0] start_mid = 4'h7;
  localparam logic [3:0] tx_stop_idx8 = 4'h9;
  localparam logic [3:0] tx_stop_idx9 = 4'hA;
  localparam logic [3:0] rx_last_idx8 = 4'h8;
  localparam logic [3:0] rx_last_idx9 = 4'h9;
  localparam logic [3:0] sync_last_bit = 4'h7;
  localparam logic [7:0] t1_top = 8'hFF;
  localparam logic [15:0] t2_top = 16'hFFFF;
  localparam logic [1:0] m2_div4_last = 2'h3;

  // bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [2:0] {xf_idle, xf_async, xf_sync_tx, xf_sync_rx, xf_sync_fin} xfer_type;
  typedef enum logic [1:0] {rs_idle, rs_start, rs_data} rx_state_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    // bus slave
    logic aw_ready;
    logic w_ready;
    logic ar_ready;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // software visible
    logic [1:0] mode;
    logic mpc;
    logic ren;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
    logic doubler;
    logic t1_sys;
    logic t1_ext;
    logic [7:0] t1_reload;
    logic [7:0] t2_rl_lo;
    logic [7:0] t2_rl_hi;
    logic rx_t2;
    logic tx_t2;
    logic t2_ext;
    logic irq_en;
    logic [7:0] rx_hold;
    // timers
    logic [3:0] pre12;
    logic [7:0] t1_cnt;
    logic t1_half;
    logic [15:0] t2_cnt;
    logic t2_half;
    logic t1_pin_q;
    logic t2_pin_q;
    logic [1:0] m2_pre;
    // transmit and mode 0 engine
    xfer_type xf;
    logic [10:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_ticks;
    logic [3:0] sync_cnt;
    // async receiver
    rx_state_type rs;
    logic [9:0] rx_sh;
    logic [3:0] rx_bits;
    logic [3:0] rx_ticks;
    logic rx_prev;
    // pins
    logic tx_out;
    logic rx_out;
    logic rx_oe;
    logic irq;
    logic t2_irq_inhibit;
  } state_type;

endpackage

/* src/serial_port_uart.sv */
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module serial_port_uart (
  input wire logic aclk,
  input wire logic aresetn,
  input wire uart_pkg::axi_req_type axi_req,
  output uart_pkg::axi_rsp_type axi_rsp,
  input wire logic rx_in,
  output logic rx_out,
  output logic rx_oe,
  output logic tx_out,
  input wire logic timer1_ext_pin,
  input wire logic timer2_ext_pin,
  output logic irq,
  output logic timer2_irq_inhibit
);

  uart_pkg::state_type s_reg;
  uart_pkg::state_type s_next;

  logic t1_in;
  logic t1_ovf;
  logic t1_tick16;
  logic t2_run;
  logic t2_in;
  logic t2_ovf;
  logic m2_tick;
  logic tx_tick;
  logic rx_tick;
  logic wr_go;
  logic tx_start;
  logic [3:0] tx_stop_idx;
  logic [3:0] rx_last_idx;
  logic [9:0] rx_done_sh;
  logic [7:0] rx_byte;
  logic rx_bit9;

  // only the decoded offsets answer okay; anything else gets slverr
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == uart_pkg::buffer_offset) || (a == uart_pkg::control_offset)
      || (a == uart_pkg::power_offset) || (a == uart_pkg::clock_offset)
      || (a == uart_pkg::t1_reload_offset) || (a == uart_pkg::t2_reload_low_offset)
      || (a == uart_pkg::t2_reload_high_offset) || (a == uart_pkg::t2_control_offset)
      || (a == uart_pkg::irq_enable_offset);
  endfunction

  // 16x tick for one direction; each direction has its own timer 2 select
  function automatic logic baud_tick(input logic [1:0] mode, input logic use_t2,
    input logic t2o, input logic t1t, input logic m2t);
    if (mode == uart_pkg::mode_async9_fixed)
      baud_tick = m2t;
    else if (use_t2)
      baud_tick = t2o;
    else
      baud_tick = t1t;
  endfunction

  always_comb
  begin
    s_next = s_reg;

    // timer 1: clock from system clock, system clock over 12, or its pin
    s_next.pre12 = (s_reg.pre12 == uart_pkg::sync_div_last) ? 4'h0 : s_reg.pre12 + 4'h1;
    s_next.t1_pin_q = timer1_ext_pin;
    s_next.t2_pin_q = timer2_ext_pin;
    if (s_reg.t1_ext)
      t1_in = timer1_ext_pin & ~s_reg.t1_pin_q;
    else if (s_reg.t1_sys)
      t1_in = 1'b1;
    else
      t1_in = (s_reg.pre12 == uart_pkg::sync_div_last);
    t1_ovf = t1_in && (s_reg.t1_cnt == uart_pkg::t1_top);
    if (t1_in)
      s_next.t1_cnt = t1_ovf ? s_reg.t1_reload : s_reg.t1_cnt + 8'h01;
    if (t1_ovf)
      s_next.t1_half = ~s_reg.t1_half;
    // without the doubler every other overflow is dropped: rate/32 instead of /16
    t1_tick16 = t1_ovf && (s_reg.doubler || s_reg.t1_half);

    // timer 2 only runs as a baud generator here; it stands still otherwise
    t2_run = s_reg.rx_t2 || s_reg.tx_t2;
    s_next.t2_half = ~s_reg.t2_half;
    if (s_reg.t2_ext)
      t2_in = t2_run && timer2_ext_pin && !s_reg.t2_pin_q;
    else
      t2_in = t2_run && s_reg.t2_half;
    t2_ovf = t2_in && (s_reg.t2_cnt == uart_pkg::t2_top);
    if (t2_in)
      s_next.t2_cnt = t2_ovf ? {s_reg.t2_rl_hi, s_reg.t2_rl_lo} : s_reg.t2_cnt + 16'h0001;
    else if (!t2_run)
      s_next.t2_cnt = {s_reg.t2_rl_hi, s_reg.t2_rl_lo}; // held at reload while stopped
    s_next.t2_irq_inhibit = t2_run;

    // fixed mode 2 rate: 16x tick every 2 or 4 clocks
    s_next.m2_pre = s_reg.m2_pre + 2'h1;
    m2_tick = s_reg.doubler ? s_reg.m2_pre[0] : (s_reg.m2_pre == uart_pkg::m2_div4_last);
    tx_tick = baud_tick(s_reg.mode, s_reg.tx_t2, t2_ovf, t1_tick16, m2_tick);
    rx_tick = baud_tick(s_reg.mode, s_reg.rx_t2, t2_ovf, t1_tick16, m2_tick);

    // bus write channels, taken in either order
    if (axi_req.awvalid && s_reg.aw_ready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_reg.w_ready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = axi_req.wdata[7:0];
      s_next.w_lane0 = axi_req.wstrb[0];
    end
    wr_go = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    tx_start = 1'b0;
    if (s_reg.bvalid && axi_req.bready)
      s_next.bvalid = 1'b0;
    if (wr_go)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = addr_known(s_reg.aw_addr) ? uart_pkg::resp_okay : uart_pkg::resp_slverr;
      if (s_reg.w_lane0)
      begin
        case (s_reg.aw_addr)
          uart_pkg::buffer_offset: tx_start = 1'b1;
          uart_pkg::control_offset:
          begin
            s_next.mode = s_reg.w_data[uart_pkg::ctl_mode_hi:uart_pkg::ctl_mode_lo];
            s_next.mpc = s_reg.w_data[uart_pkg::ctl_mpc];
            s_next.ren = s_reg.w_data[uart_pkg::ctl_ren];
            s_next.tx_ninth = s_reg.w_data[uart_pkg::ctl_tx_ninth];
            s_next.rx_ninth = s_reg.w_data[uart_pkg::ctl_rx_ninth];
            s_next.tx_done = s_reg.w_data[uart_pkg::ctl_tx_done];
            s_next.rx_done = s_reg.w_data[uart_pkg::ctl_rx_done];
          end
          uart_pkg::power_offset: s_next.doubler = s_reg.w_data[uart_pkg::pwr_doubler];
          uart_pkg::clock_offset:
          begin
            s_next.t1_sys = s_reg.w_data[uart_pkg::clk_t1_sys];
            s_next.t1_ext = s_reg.w_data[uart_pkg::clk_t1_ext];
          end
          uart_pkg::t1_reload_offset: s_next.t1_reload = s_reg.w_data;
          uart_pkg::t2_reload_low_offset: s_next.t2_rl_lo = s_reg.w_data;
          uart_pkg::t2_reload_high_offset: s_next.t2_rl_hi = s_reg.w_data;
          uart_pkg::t2_control_offset:
          begin
            s_next.rx_t2 = s_reg.w_data[uart_pkg::t2_rx_sel];
            s_next.tx_t2 = s_reg.w_data[uart_pkg::t2_tx_sel];
            s_next.t2_ext = s_reg.w_data[uart_pkg::t2_ext_sel];
          end
          uart_pkg::irq_enable_offset: s_next.irq_en = s_reg.w_data[uart_pkg::irq_en_bit];
          default: tx_start = 1'b0; // unmapped: nothing written, slverr stands
        endcase
      end
    end

    // bus read: one cycle to rvalid, reads have no side effects
    if (s_reg.rvalid && axi_req.rready)
      s_next.rvalid = 1'b0;
    if (axi_req.arvalid && s_reg.ar_ready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = addr_known(axi_req.araddr) ? uart_pkg::resp_okay : uart_pkg::resp_slverr;
      case (axi_req.araddr)
        uart_pkg::buffer_offset: s_next.rdata = s_reg.rx_hold;
        uart_pkg::control_offset:
          s_next.rdata = {s_reg.mode, s_reg.mpc, s_reg.ren, s_reg.tx_ninth, s_reg.rx_ninth,
            s_reg.tx_done, s_reg.rx_done};
        uart_pkg::power_offset: s_next.rdata = {s_reg.doubler, 7'h00};
        uart_pkg::clock_offset: s_next.rdata = {3'h0, s_reg.t1_sys, s_reg.t1_ext, 3'h0};
        uart_pkg::t1_reload_offset: s_next.rdata = s_reg.t1_reload;
        uart_pkg::t2_reload_low_offset: s_next.rdata = s_reg.t2_rl_lo;
        uart_pkg::t2_reload_high_offset: s_next.rdata = s_reg.t2_rl_hi;
        uart_pkg::t2_control_offset:
          s_next.rdata = {2'h0, s_reg.rx_t2, s_reg.tx_t2, 2'h0, s_reg.t2_ext, 1'b0};
        uart_pkg::irq_enable_offset: s_next.rdata = {7'h00, s_reg.irq_en};
        default: s_next.rdata = 8'h00;
      endcase
    end

    // transmit engine, also runs the half-duplex mode 0 transfers
    tx_stop_idx = (s_reg.mode == uart_pkg::mode_async8) ? uart_pkg::tx_stop_idx8
      : uart_pkg::tx_stop_idx9;
    s_next.sync_cnt = (s_reg.sync_cnt == uart_pkg::sync_div_last) ? 4'h0
      : s_reg.sync_cnt + 4'h1;
    case (s_reg.xf)
      uart_pkg::xf_idle:
      begin
        s_next.tx_out = 1'b1;
        s_next.rx_oe = 1'b0;
        s_next.sync_cnt = 4'h0;
        s_next.tx_bits = 4'h0;
        s_next.tx_ticks = 4'h0;
        if (tx_start && s_reg.mode == uart_pkg::mode_sync)
        begin
          s_next.xf = uart_pkg::xf_sync_tx;
          s_next.tx_sh = {3'h7, s_reg.w_data};
          s_next.rx_oe = 1'b1;
          s_next.rx_out = s_reg.w_data[0];
          s_next.tx_out = 1'b0;
        end
        else if (tx_start)
        begin
          s_next.xf = uart_pkg::xf_async;
          // mode 1 puts a stop in the ninth slot; frame ends one bit early
          s_next.tx_sh = {1'b1, (s_reg.mode == uart_pkg::mode_async8) ? 1'b1 : s_reg.tx_ninth,
            s_reg.w_data, 1'b0};
          s_next.tx_out = 1'b0;
        end
        else if (s_reg.mode == uart_pkg::mode_sync && s_reg.ren && !s_reg.rx_done)
        begin
          s_next.xf = uart_pkg::xf_sync_rx;
          s_next.tx_out = 1'b0;
        end
      end
      uart_pkg::xf_async:
      begin
        if (tx_tick)
        begin
          s_next.tx_ticks = s_reg.tx_ticks + 4'h1;
          if (s_reg.tx_ticks == uart_pkg::oversample_last)
          begin
            s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
            s_next.tx_bits = s_reg.tx_bits + 4'h1;
            if (s_reg.tx_bits == tx_stop_idx)
              s_next.xf = uart_pkg::xf_idle;
            else if (s_reg.tx_bits + 4'h1 == tx_stop_idx)
              s_next.tx_done = 1'b1;
          end
        end
        s_next.tx_out = s_next.tx_sh[0];
      end
      uart_pkg::xf_sync_tx, uart_pkg::xf_sync_rx:
      begin
        // shift clock low in the first half of each bit, high in the second
        s_next.tx_out = (s_next.sync_cnt >= uart_pkg::sync_div_half);
        if (s_reg.sync_cnt == uart_pkg::sync_div_last)
        begin
          s_next.tx_bits = s_reg.tx_bits + 4'h1;
          s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
          s_next.rx_out = s_next.tx_sh[0];
          if (s_reg.xf == uart_pkg::xf_sync_rx)
            s_next.rx_sh = {rx_in, s_reg.rx_sh[9:1]};
          if (s_reg.tx_bits == uart_pkg::sync_last_bit)
          begin
            s_next.tx_out = 1'b1;
            s_next.rx_oe = 1'b0;
            if (s_reg.xf == uart_pkg::xf_sync_tx)
            begin
              s_next.tx_done = 1'b1;
              s_next.xf = uart_pkg::xf_idle;
            end
            else
              s_next.xf = uart_pkg::xf_sync_fin;
          end
        end
      end
      uart_pkg::xf_sync_fin:
      begin
        // one cycle after the last bit; receive then waits for the flag clear
        s_next.rx_done = 1'b1;
        s_next.rx_hold = s_reg.rx_sh[9:2];
        s_next.xf = uart_pkg::xf_idle;
      end
      default: s_next.xf = uart_pkg::xf_idle;
    endcase

    // asynchronous receiver, full duplex with the transmitter
    rx_last_idx = (s_reg.mode == uart_pkg::mode_async8) ? uart_pkg::rx_last_idx8
      : uart_pkg::rx_last_idx9;
    rx_done_sh = {rx_in, s_reg.rx_sh[9:1]};
    rx_byte = (s_reg.mode == uart_pkg::mode_async8) ? rx_done_sh[8:1] : rx_done_sh[7:0];
    rx_bit9 = (s_reg.mode == uart_pkg::mode_async8) ? rx_done_sh[9] : rx_done_sh[8];
    s_next.rx_prev = rx_in;
    case (s_reg.rs)
      uart_pkg::rs_idle:
      begin
        s_next.rx_ticks = 4'h0;
        s_next.rx_bits = 4'h0;
        if (s_reg.ren && s_reg.mode != uart_pkg::mode_sync && s_reg.rx_prev && !rx_in)
          s_next.rs = uart_pkg::rs_start;
      end
      uart_pkg::rs_start:
      begin
        if (rx_tick)
        begin
          s_next.rx_ticks = s_reg.rx_ticks + 4'h1;
          if (s_reg.rx_ticks == uart_pkg::start_mid)
          begin
            // a glitch that is high again mid-bit is not a start bit
            s_next.rs = rx_in ? uart_pkg::rs_idle : uart_pkg::rs_data;
            s_next.rx_ticks = 4'h0;
          end
        end
      end
      uart_pkg::rs_data:
      begin
        if (rx_tick)
        begin
          s_next.rx_ticks = s_reg.rx_ticks + 4'h1;
          if (s_reg.rx_ticks == uart_pkg::oversample_last)
          begin
            s_next.rx_sh = rx_done_sh;
            s_next.rx_bits = s_reg.rx_bits + 4'h1;
            if (s_reg.rx_bits == rx_last_idx)
            begin
              s_next.rs = uart_pkg::rs_idle;
              if (!s_reg.rx_done && (!s_reg.mpc || rx_bit9))
              begin
                s_next.rx_hold = rx_byte;
                s_next.rx_ninth = rx_bit9;
                s_next.rx_done = 1'b1;
              end
            end
          end
        end
      end
      default: s_next.rs = uart_pkg::rs_idle;
    endcase

    // interrupt and bus ready terms follow the updated state, except irq_en, which is taken from the register
    s_next.irq = s_reg.irq_en && (s_next.tx_done || s_next.rx_done);
    s_next.aw_ready = !s_next.aw_got && !s_next.bvalid;
    s_next.w_ready = !s_next.w_got && !s_next.bvalid;
    s_next.ar_ready = !s_next.rvalid;
  end

  // single state register; idle lines and ready terms reset high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.tx_out <= 1'b1;
      s_reg.rx_out <= 1'b1;
      s_reg.rx_prev <= 1'b1;
      s_reg.aw_ready <= 1'b1;
      s_reg.w_ready <= 1'b1;
      s_reg.ar_ready <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign axi_rsp.awready = s_reg.aw_ready;
  assign axi_rsp.wready = s_reg.w_ready;
  assign axi_rsp.bvalid = s_reg.bvalid;
  assign axi_rsp.bresp = s_reg.bresp;
  assign axi_rsp.arready = s_reg.ar_ready;
  assign axi_rsp.rvalid = s_reg.rvalid;
  assign axi_rsp.rdata = {24'h000000, s_reg.rdata};
  assign axi_rsp.rresp = s_reg.rresp;
  assign rx_out = s_reg.rx_out;
  assign rx_oe = s_reg.rx_oe;
  assign tx_out = s_reg.tx_out;
  assign irq = s_reg.irq;
  assign timer2_irq_inhibit = s_reg.t2_irq_inhibit;

endmodule // serial_port_uart

/* sim/serial_port_uart_sva.sv */
`timescale 1ns/1ps
module serial_port_uart_sva (
  input logic aclk,
  input logic aresetn,
  input uart_pkg::axi_req_type axi_req,
  input uart_pkg::axi_rsp_type axi_rsp,
  input logic rx_in,
  input logic rx_out,
  input logic rx_oe,
  input logic tx_out,
  input logic timer1_ext_pin,
  input logic timer2_ext_pin,
  input logic irq,
  input logic timer2_irq_inhibit
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address and data taken on one edge, answer lands two edges on
  sequence both_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence late_resp;
    ##1 !axi_rsp.bvalid ##1 axi_rsp.bvalid;
  endsequence
  // only a software write may take a level down
  sequence recent_write;
    axi_rsp.bvalid || $past(axi_rsp.bvalid) || $past(axi_rsp.bvalid, 2);
  endsequence
  wr_answer_a: assert property (both_taken |-> late_resp)
    else $error("write response not two edges after capture");
  rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid && !axi_rsp.arready) else $error("read answer late");
  rd_upper_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  irq_clear_a: assert property ($fell(irq) |-> recent_write)
    else $error("irq dropped without a write");
  inhibit_a: assert property ($changed(timer2_irq_inhibit) |-> recent_write)
    else $error("timer 2 inhibit moved without a write");
  m0_start_a: assert property ($rose(rx_oe) |-> !tx_out)
    else $error("shift clock not low when drive starts");
  m0_high_a: assert property ($rose(tx_out) && rx_oe |-> tx_out [*6])
    else $error("shift clock high phase short");
  m0_low_a: assert property ($fell(tx_out) && rx_oe |-> !tx_out [*6])
    else $error("shift clock low phase short");
  m0_data_a: assert property (rx_oe && $changed(rx_out) |-> $fell(tx_out))
    else $error("shift data moved off the falling clock");
endmodule // serial_port_uart_sva

bind serial_port_uart serial_port_uart_sva i_sva (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .rx_in(rx_in), .rx_out(rx_out), .rx_oe(rx_oe),
  .tx_out(tx_out), .timer1_ext_pin(timer1_ext_pin), .timer2_ext_pin(timer2_ext_pin),
  .irq(irq), .timer2_irq_inhibit(timer2_irq_inhibit));

/* sim/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  input logic clk,
  input logic tx_line,
  input logic rx_out,
  input logic rx_oe,
  input logic m0,
  input int bit_clks,
  input int nb,
  output logic rx_in,
  output logic [9:0] got,
  output int got_n
);
  logic a_lvl = 1'b1;
  logic [7:0] sl = 8'h00;
  logic armed = 1'b0;
  logic [7:0] m0v = 8'h00;
  logic [9:0] v;
  int m0c = 0;
  // shared data pin: the block wins while it drives, idle async line pulled high
  assign rx_in = rx_oe ? rx_out : (m0 ? sl[0] : a_lvl);
  // one frame: start, data lsb first, stop, then one idle bit
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      a_lvl <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    a_lvl <= 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask
  task automatic load(input logic [7:0] d);
    sl = d;
    armed = 1'b0;
  endtask
  // decode the block's frames at bit centres; a wrong bit length garbles them
  always
  begin
    @(negedge tx_line);
    if (!m0)
    begin
      v = 10'h000;
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i <= nb; i++)
      begin
        repeat (bit_clks) @(posedge clk);
        v[i] = tx_line;
      end
      got = v;
      got_n <= got_n + 1;
    end
  end
  // mode 0: capture on rising clock, or arm our own shifter when receiving
  always @(posedge tx_line)
    if (rx_oe)
    begin
      m0v = {rx_out, m0v[7:1]};
      m0c++;
      if (m0c == 8)
      begin
        got = {2'b01, m0v};
        got_n <= got_n + 1;
        m0c = 0;
      end
    end
    else if (m0)
      armed = 1'b1;
  // next bit after each sampled pulse; shifted-in filler differs from the last bit
  always @(negedge tx_line)
    if (armed)
      sl = {~sl[0], sl[7:1]};
endmodule // serial_peer

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  uart_pkg::axi_req_type req;
  uart_pkg::axi_rsp_type rsp;
  logic rx_in, rx_out, rx_oe, tx_out, irq, t2_inh;
  logic pin1 = 1'b0;
  logic pin2 = 1'b0;
  logic m0 = 1'b0;
  int bit_clks = 16;
  int nb = 8;
  logic [9:0] got;
  int got_n;
  int n_fail = 0;
  int num_checks = 0;
  logic [33:0] rd_q[$];
  logic [9:0] ser_q[$];
  logic [1:0] wr_q[$];
  always #50 aclk = ~aclk;
  // external timer inputs rise once every two clocks
  always @(posedge aclk)
  begin
    pin1 <= ~pin1;
    pin2 <= ~pin2;
  end
  serial_port_uart i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rx_in(rx_in), .rx_out(rx_out), .rx_oe(rx_oe), .tx_out(tx_out), .timer1_ext_pin(pin1),
    .timer2_ext_pin(pin2), .irq(irq), .timer2_irq_inhibit(t2_inh));
  serial_peer i_peer (.clk(aclk), .tx_line(tx_out), .rx_out(rx_out), .rx_oe(rx_oe), .m0(m0),
    .bit_clks(bit_clks), .nb(nb), .rx_in(rx_in), .got(got), .got_n(got_n));
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // answers and frames are matched against the oldest note
  always @(posedge aclk)
    if (rsp.rvalid === 1'b1)
      chk("read", {rsp.rresp, rsp.rdata}, rd_q.pop_front());
  always @(posedge aclk)
    if (rsp.bvalid === 1'b1)
      chk("bresp", {32'h0, rsp.bresp}, {32'h0, wr_q.pop_front()});
  always @(got_n)
    chk("frame", {24'h0, got}, {24'h0, ser_q.pop_front()});
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r = uart_pkg::resp_okay);
    logic aw;
    logic w;
    wr_q.push_back(r);
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      aw = aw && (rsp.awready !== 1'b1);
      w = w && (rsp.wready !== 1'b1);
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    while (aw || w);
    do
      @(posedge aclk);
    while (rsp.bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [7:0] e);
    rd_q.push_back({r, 24'h0, e});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rsp.rvalid !== 1'b1);
  endtask
  task automatic wait_got();
    int n0;
    n0 = got_n;
    while (got_n == n0)
      @(posedge aclk);
  endtask
  // configure, send a random byte, then check the done flag and the untouched rx side
  task automatic row(input logic [7:0] ctl, input logic [7:0] pw, input logic [7:0] ck,
      input logic [7:0] t2c, input int bc, input int n);
    logic [7:0] d;
    d = 8'($urandom());
    bit_clks = bc;
    nb = n;
    wr(uart_pkg::power_offset, pw);
    wr(uart_pkg::clock_offset, ck);
    wr(uart_pkg::t2_control_offset, t2c);
    wr(uart_pkg::control_offset, ctl);
    ser_q.push_back(n == 8 ? {2'b01, d} : {1'b1, ctl[uart_pkg::ctl_tx_ninth], d});
    wr(uart_pkg::buffer_offset, d);
    wait_got();
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, ctl | 8'h02);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, 8'h00);
    repeat (bc) @(posedge aclk);
  endtask
  initial
  begin
    logic [7:0] d1;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    void'($urandom(32'h4E3B8078));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, 8'h00);
    rd(8'h24, uart_pkg::resp_slverr, 8'h00);
    wr(8'h24, 8'h5A, uart_pkg::resp_slverr);
    wr(uart_pkg::t1_reload_offset, 8'hFF);
    wr(uart_pkg::t2_reload_low_offset, 8'hFF);
    wr(uart_pkg::t2_reload_high_offset, 8'hFF);
    // timer 1 counts up from zero after reset: let it reach its first reload
    wr(uart_pkg::clock_offset, 8'h10);
    repeat (260) @(posedge aclk);
    row(8'h40, 8'h80, 8'h10, 8'h00, 16, 8);
    row(8'h40, 8'h00, 8'h10, 8'h00, 32, 8);
    row(8'h40, 8'h80, 8'h00, 8'h00, 192, 8);
    row(8'h40, 8'h80, 8'h18, 8'h00, 32, 8);
    row(8'h40, 8'h80, 8'h10, 8'h20, 16, 8);
    row(8'h40, 8'h00, 8'h00, 8'h10, 32, 8);
    row(8'h40, 8'h00, 8'h00, 8'h12, 32, 8);
    chk("inhibit", {33'h0, t2_inh}, 34'h1);
    row(8'hC8, 8'h80, 8'h10, 8'h00, 16, 9);
    row(8'h88, 8'h80, 8'h10, 8'h00, 32, 9);
    row(8'h80, 8'h00, 8'h10, 8'h00, 64, 9);
    // async receive, a frame dropped while the flag is set, then the irq
    bit_clks = 32;
    d1 = 8'($urandom());
    wr(uart_pkg::control_offset, 8'h50);
    i_peer.send(d1, 1'b1);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, d1);
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, 8'h55);
    i_peer.send(8'($urandom()), 1'b1);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, d1);
    wr(uart_pkg::irq_enable_offset, 8'h01);
    repeat (3) @(posedge aclk);
    chk("irq", {33'h0, irq}, 34'h1);
    wr(uart_pkg::control_offset, 8'h70);
    repeat (3) @(posedge aclk);
    chk("irq", {33'h0, irq}, 34'h0);
    i_peer.send(8'($urandom()), 1'b0);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, d1);
    d1 = 8'($urandom());
    i_peer.send(d1, 1'b1);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, d1);
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, 8'h75);
    // mode 0: clocked reception, then a transmission; leave async receive first
    wr(uart_pkg::control_offset, 8'h00);
    m0 <= 1'b1;
    d1 = 8'($urandom());
    i_peer.load(d1);
    wr(uart_pkg::control_offset, 8'h10);
    repeat (110) @(posedge aclk);
    rd(uart_pkg::buffer_offset, uart_pkg::resp_okay, d1);
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, 8'h11);
    wr(uart_pkg::control_offset, 8'h00);
    d1 = 8'($urandom());
    ser_q.push_back({2'b01, d1});
    wr(uart_pkg::buffer_offset, d1);
    wait_got();
    repeat (12) @(posedge aclk);
    rd(uart_pkg::control_offset, uart_pkg::resp_okay, 8'h02);
    stop_test();
  end
  // about four times the expected run
  initial
  begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    stop_test();
  end
endmodule // tb_top
